// ---- core/sbee_pkg.sv ----
package sbee_pkg;

  // array shape
  localparam int MEM_DEPTH = 512;      // stored bytes
  localparam int DATA_W    = 8;        // bits per byte
  localparam int MAR_W     = 10;       // memory address register, reaches the special locations
  localparam int IDX_W     = 9;        // index into the array

  // serial bus framing
  localparam logic [4:0] CNT_ADDR = 5'h08;  // address bits per address phase
  localparam logic [4:0] CNT_WORD = 5'h10;  // bits per data word

  // function addresses, strap low and strap high
  localparam logic [7:0] ADR_LOAD_LO = 8'h80;  // 128
  localparam logic [7:0] ADR_READ_LO = 8'h81;  // 129
  localparam logic [7:0] ADR_PROG_LO = 8'h83;  // 131
  localparam logic [7:0] ADR_LOAD_HI = 8'h84;  // 132
  localparam logic [7:0] ADR_READ_HI = 8'h85;  // 133
  localparam logic [7:0] ADR_PROG_HI = 8'h87;  // 135

  // special location and protected field
  localparam logic [9:0] BUSY_LOC  = 10'h20e;  // 526, busy flag lives here
  localparam int         BUSY_BIT  = 1;        // bit of the busy flag in that byte
  localparam int         PROT_LSB  = 4;        // protected when these address bits are zero
  localparam int         PROT_MSB  = 5;
  localparam logic [7:0] IDLE_BYTE = 8'hff;    // released lines read as ones

  // programming time
  localparam int CLK_HZ      = 20_000_000;
  localparam int PROG_MIN_MS = 8;              // shortest erase or write time
  localparam int PROG_MAX_MS = 30;             // longest erase or write time
  localparam int PROG_CYCLES = (CLK_HZ / 1000) * PROG_MIN_MS;

  // sync input reset levels: strap, safe, data, ident, clock
  localparam logic [4:0] SYNC_RST = 5'h07;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } sbee_state_t;

  typedef enum logic [1:0] {
    FN_NONE = 2'h0,
    FN_LOAD = 2'h1,
    FN_READ = 2'h2,
    FN_PROG = 2'h3
  } sbee_func_t;

endpackage : sbee_pkg

// ---- core/sbee_sync.sv ----
`timescale 1ns/100ps
// two-flop synchroniser for pins that come from outside the core clock
module sbee_sync #(
  parameter int           W       = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;  // first stage, read by the second stage only

  // sync reset to idle levels so edge detectors see nothing spurious
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sbee_sync

// ---- core/sbee_core.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - 512 bytes, addressed through memory address register
// - protected bytes programmable only with guard high
// - strap low: answer addresses 128, 129, 131
// - strap high: answer addresses 132, 133, 135
// - lowest loads address, next reads, highest programs
// - reset low aborts programming and bus transfer
// - memory address register survives reset
// - self-timed programming between 8 and 30 ms
// - eight address bits, lsb first, rising clock
// - read drives byte within 16-bit word, open drain
// - location 526 bit 1 shows busy
// - busy ignores new programming and address loads other than 526, which redirect the next read
module sbee_core #(
  parameter int PROG_CYCLES = sbee_pkg::PROG_CYCLES  // cycles of one programming pass
) (
  input  wire logic CORE_CLK,
  input  wire logic RESETN,
  input  wire logic BUS_CLK,        // bus clock pin, idles high
  input  wire logic BUS_IDENT,      // address-phase strobe pin, low during address
  input  wire logic BUS_DATA_IN,    // data line level
  output logic      BUS_DATA_OUT,   // data line drive value, always low
  output logic      BUS_DATA_OE_N,  // low while pulling the data line low
  input  wire logic SAFE,           // write guard, high unlocks protected bytes
  input  wire logic OPTION          // address-set strap
);

  localparam int TW = $clog2(PROG_CYCLES + 1);  // timer width

  logic [4:0]                    s_pins;     // synchronised pins
  logic                          s_clk;      // synced bus clock
  logic                          s_id;       // synced strobe
  logic                          s_din;      // synced data line
  logic                          s_safe;     // synced guard
  logic                          s_opt;      // synced strap
  logic                          clk_p_q;    // bus clock one cycle ago
  logic                          id_p_q;     // strobe one cycle ago
  logic                          clk_rise;   // bus clock rising edge
  logic                          clk_fall;   // bus clock falling edge
  logic                          id_rise;    // strobe rising edge
  logic                          id_fall;    // strobe falling edge
  sbee_pkg::sbee_state_t         st_q;       // bus transaction state
  sbee_pkg::sbee_func_t          fn_q;       // function chosen by the address
  sbee_pkg::sbee_func_t          fn_dec;     // decoded function of the address byte
  logic [4:0]                    cnt_q;      // bits seen in this phase
  logic [7:0]                    ash_q;      // address byte shifter
  logic [15:0]                   wsh_q;      // received data word shifter
  logic [15:0]                   tx_q;       // outgoing word, lsb first
  logic [sbee_pkg::MAR_W-1:0]    mar_q;      // memory address register, no reset
  logic                          busy_q;     // programming cycle running
  logic [TW-1:0]                 tmr_q;      // programming timer
  logic [sbee_pkg::IDX_W-1:0]    wr_idx_q;   // byte being programmed
  logic [sbee_pkg::DATA_W-1:0]   wr_byte_q;  // value being programmed
  logic                          safe_ok_q;  // guard high since transaction start
  logic                          exec;       // end of a complete data word
  logic                          do_load;    // accepted address load
  logic                          do_prog;    // accepted programming start
  logic [sbee_pkg::DATA_W-1:0]   rd_byte;    // byte returned by a read
  logic                          mar_seen_q; // helper: register has been loaded once
  logic                          poll_q;     // next read returns the busy byte

  // storage array, never reset: contents are non-volatile
  logic [sbee_pkg::DATA_W-1:0] mem [sbee_pkg::MEM_DEPTH];

  sbee_sync #(
    .W       (5),
    .RST_VAL (sbee_pkg::SYNC_RST)
  ) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RESETN),
    .d     ({OPTION, SAFE, BUS_DATA_IN, BUS_IDENT, BUS_CLK}),
    .q     (s_pins)
  );

  assign s_clk  = s_pins[0];
  assign s_id   = s_pins[1];
  assign s_din  = s_pins[2];
  assign s_safe = s_pins[3];
  assign s_opt  = s_pins[4];

  // map an address byte to a function for the strapped address set
  function automatic sbee_pkg::sbee_func_t decode_fn(input logic [7:0] a, input logic hi);
    sbee_pkg::sbee_func_t f;
    f = sbee_pkg::FN_NONE;
    if (!hi) begin
      if (a == sbee_pkg::ADR_LOAD_LO) f = sbee_pkg::FN_LOAD;
      else if (a == sbee_pkg::ADR_READ_LO) f = sbee_pkg::FN_READ;
      else if (a == sbee_pkg::ADR_PROG_LO) f = sbee_pkg::FN_PROG;
    end else begin
      if (a == sbee_pkg::ADR_LOAD_HI) f = sbee_pkg::FN_LOAD;
      else if (a == sbee_pkg::ADR_READ_HI) f = sbee_pkg::FN_READ;
      else if (a == sbee_pkg::ADR_PROG_HI) f = sbee_pkg::FN_PROG;
    end
    return f;
  endfunction : decode_fn

  // protected bytes sit where the two guard bits of the address are zero
  function automatic logic is_prot(input logic [sbee_pkg::MAR_W-1:0] a);
    return a[sbee_pkg::PROT_MSB:sbee_pkg::PROT_LSB] == '0;
  endfunction : is_prot

  assign fn_dec   = decode_fn(ash_q, s_opt);
  assign clk_rise = s_clk & ~clk_p_q;
  assign clk_fall = ~s_clk & clk_p_q;
  assign id_rise  = s_id & ~id_p_q;
  assign id_fall  = ~s_id & id_p_q;
  // the next strobe fall closes the data word
  assign exec     = (st_q == sbee_pkg::ST_DATA) && id_fall && (cnt_q == sbee_pkg::CNT_WORD);
  assign do_load  = exec && (fn_q == sbee_pkg::FN_LOAD) && !busy_q;
  assign do_prog  = exec && (fn_q == sbee_pkg::FN_PROG) && !busy_q
                    && (mar_q < sbee_pkg::MAR_W'(sbee_pkg::MEM_DEPTH))
                    && (!is_prot(mar_q) || safe_ok_q);

  // busy byte at the special location or after a busy-time load of 526, otherwise the stored byte; out of range reads ones
  always_comb begin
    rd_byte = sbee_pkg::IDLE_BYTE;
    if (poll_q || mar_q == sbee_pkg::BUSY_LOC) begin
      rd_byte                    = '0;
      rd_byte[sbee_pkg::BUSY_BIT] = busy_q;
    end else if (mar_q < sbee_pkg::MAR_W'(sbee_pkg::MEM_DEPTH)) begin
      rd_byte = mem[mar_q[sbee_pkg::IDX_W-1:0]];
    end
  end

  // edge history of the synced bus lines
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      clk_p_q <= 1'b1;
      id_p_q  <= 1'b1;
    end else begin
      clk_p_q <= s_clk;
      id_p_q  <= s_id;
    end
  end

  // transaction sequencer; a reset drops any transfer half way
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_q  <= sbee_pkg::ST_IDLE;
      fn_q  <= sbee_pkg::FN_NONE;
      cnt_q <= '0;
      ash_q <= '0;
      wsh_q <= '0;
    end else begin
      case (st_q)
        sbee_pkg::ST_IDLE: begin
          if (id_fall) begin
            st_q  <= sbee_pkg::ST_ADDR;
            cnt_q <= '0;
          end
        end
        sbee_pkg::ST_ADDR: begin
          if (id_rise) begin
            // an end pulse with no bits or a foreign address falls back to idle
            if (cnt_q == sbee_pkg::CNT_ADDR && fn_dec != sbee_pkg::FN_NONE) begin
              st_q <= sbee_pkg::ST_DATA;
              fn_q <= fn_dec;
            end else begin
              st_q <= sbee_pkg::ST_IDLE;
              fn_q <= sbee_pkg::FN_NONE;
            end
            cnt_q <= '0;
          end else if (clk_rise && cnt_q != sbee_pkg::CNT_ADDR) begin
            ash_q <= {s_din, ash_q[7:1]};
            cnt_q <= cnt_q + 5'h01;
          end
        end
        sbee_pkg::ST_DATA: begin
          if (id_fall) begin
            // the strobe fall is either an end pulse or the next address phase
            st_q  <= sbee_pkg::ST_ADDR;
            fn_q  <= sbee_pkg::FN_NONE;
            cnt_q <= '0;
          end else if (clk_rise && cnt_q != sbee_pkg::CNT_WORD) begin
            wsh_q <= {s_din, wsh_q[15:1]};
            cnt_q <= cnt_q + 5'h01;
          end
        end
        default: begin
          st_q <= sbee_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // read data path: bit switched on each falling bus clock, released otherwise
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      tx_q          <= '1;
      BUS_DATA_OE_N <= 1'b1;
      BUS_DATA_OUT  <= 1'b0;
    end else begin
      BUS_DATA_OUT <= 1'b0;
      if (st_q == sbee_pkg::ST_ADDR && id_rise && cnt_q == sbee_pkg::CNT_ADDR
          && fn_dec == sbee_pkg::FN_READ) begin
        tx_q <= {sbee_pkg::IDLE_BYTE, rd_byte};
      end else if (st_q == sbee_pkg::ST_DATA && fn_q == sbee_pkg::FN_READ && !id_fall
                   && clk_fall && cnt_q != sbee_pkg::CNT_WORD) begin
        BUS_DATA_OE_N <= tx_q[0];
        tx_q          <= {1'b1, tx_q[15:1]};
      end else if (st_q != sbee_pkg::ST_DATA || id_fall) begin
        BUS_DATA_OE_N <= 1'b1;
      end
    end
  end

  // memory address register keeps its value through reset
  always_ff @(posedge CORE_CLK) begin
    if (do_load && RESETN) begin
      mar_q      <= wsh_q[sbee_pkg::MAR_W-1:0];
      mar_seen_q <= 1'b1;
    end
  end
  // a busy-time load of 526 only redirects the next read; the register stays put
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN || do_load || fn_q == sbee_pkg::FN_READ) begin
      poll_q <= 1'b0;
    end else if (exec && fn_q == sbee_pkg::FN_LOAD
                 && wsh_q[sbee_pkg::MAR_W-1:0] == sbee_pkg::BUSY_LOC) begin
      poll_q <= 1'b1;
    end
  end

  // guard must stay high from transaction start to programming start
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      safe_ok_q <= 1'b0;
    end else if (st_q == sbee_pkg::ST_IDLE && id_fall) begin
      safe_ok_q <= s_safe;
    end else if (!s_safe) begin
      safe_ok_q <= 1'b0;
    end
  end

  // self-timed programming; the byte lands only at the end, so a reset leaves it untouched
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      busy_q    <= 1'b0;
      tmr_q     <= '0;
      wr_idx_q  <= '0;
      wr_byte_q <= '0;
    end else if (do_prog) begin
      busy_q    <= 1'b1;
      tmr_q     <= '0;
      wr_idx_q  <= mar_q[sbee_pkg::IDX_W-1:0];
      wr_byte_q <= wsh_q[sbee_pkg::DATA_W-1:0];
    end else if (busy_q) begin
      if (tmr_q == TW'(PROG_CYCLES - 1)) begin
        busy_q <= 1'b0;
      end else begin
        tmr_q <= tmr_q + TW'(1);
      end
    end
  end

  // array write at the end of the timed pass
  always_ff @(posedge CORE_CLK) begin
    if (RESETN && busy_q && tmr_q == TW'(PROG_CYCLES - 1)) begin
      mem[wr_idx_q] <= wr_byte_q;
    end
  end

  AST_RESET_ABORT: assert property (@(posedge CORE_CLK)
    !RESETN |=> !busy_q && BUS_DATA_OE_N && st_q == sbee_pkg::ST_IDLE)
    else $error("reset did not abort activity");
  AST_MAR_KEEP: assert property (@(posedge CORE_CLK)
    (!RESETN && mar_seen_q) |=> $stable(mar_q))
    else $error("address register changed under reset");
  AST_PROG_TIME: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    $fell(busy_q) |-> $past(tmr_q) == TW'(PROG_CYCLES - 1))
    else $error("programming pass ended early");
  AST_BUSY_LOCK: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (busy_q && exec) |=> $stable(mar_q) && $stable(wr_byte_q) && $stable(wr_idx_q))
    else $error("busy device accepted a load or program");
  AST_GUARD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (exec && fn_q == sbee_pkg::FN_PROG && is_prot(mar_q) && !safe_ok_q) |=> !$rose(busy_q))
    else $error("protected byte programmed without guard");
  AST_ADDR_SET: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_q == sbee_pkg::ST_ADDR && id_rise && cnt_q == sbee_pkg::CNT_ADDR && !s_opt
     && ash_q != sbee_pkg::ADR_LOAD_LO && ash_q != sbee_pkg::ADR_READ_LO
     && ash_q != sbee_pkg::ADR_PROG_LO) |=> st_q == sbee_pkg::ST_IDLE)
    else $error("foreign address accepted with strap low");
  AST_ADDR_SET_HI: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_q == sbee_pkg::ST_ADDR && id_rise && cnt_q == sbee_pkg::CNT_ADDR && s_opt
     && ash_q == sbee_pkg::ADR_PROG_HI) |=> fn_q == sbee_pkg::FN_PROG)
    else $error("program address not taken with strap high");
  AST_ADDR_LSB: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_q == sbee_pkg::ST_ADDR && clk_rise && !id_rise && cnt_q < sbee_pkg::CNT_ADDR)
    |=> ash_q[7] == $past(s_din) && cnt_q == $past(cnt_q) + 5'h01)
    else $error("address bit not shifted in");
  AST_READ_DRIVE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_q == sbee_pkg::ST_DATA && fn_q == sbee_pkg::FN_READ && clk_fall && !id_fall
     && cnt_q != sbee_pkg::CNT_WORD) |=> BUS_DATA_OE_N == $past(tx_q[0]))
    else $error("read bit not driven");
  AST_BUSY_BIT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (st_q == sbee_pkg::ST_ADDR && id_rise && cnt_q == sbee_pkg::CNT_ADDR
     && fn_dec == sbee_pkg::FN_READ && (poll_q || mar_q == sbee_pkg::BUSY_LOC))
    |=> tx_q[sbee_pkg::BUSY_BIT] == $past(busy_q))
    else $error("busy bit wrong");
endmodule : sbee_core

// ---- sim/sbee_master.sv ----
`timescale 1ns/100ps
// behavioural bus master on the far side of the serial bus
module sbee_master (
  input  wire logic core_clk,   // core clock, all pin changes follow its rising edge
  input  wire logic line,       // resolved data line level
  output logic      bus_clk,    // bus clock, idles high
  output logic      bus_ident,  // strobe, low while the address goes out
  output logic      bus_drv     // open-drain pull of the master, 1 = released
);
  // all three lines idle high between transactions
  initial begin
    bus_clk   = 1'b1;
    bus_ident = 1'b1;
    bus_drv   = 1'b1;
  end

  // a half period of the 400 ns bus clock is four core cycles
  task automatic half(input int n);
    repeat (4 * n) @(posedge core_clk);
  endtask : half

  // one whole transaction: address, 16-bit word, end pulse; rd holds the line per bit
  task automatic xfer(input logic [7:0] adr, input logic [15:0] wr, output logic [15:0] rd);
    bus_ident <= 1'b0;
    half(1);
    // address bits go out lsb first, the slave takes them on the rising clock
    for (int i = 0; i < 8; i++) begin
      bus_clk <= 1'b0;
      bus_drv <= adr[i];
      half(1);
      bus_clk <= 1'b1;
      half(1);
    end
    bus_drv   <= 1'b1;
    bus_ident <= 1'b1;
    half(8);  // clock hold after ident high
    // the program byte rides in the low byte, sent first
    for (int i = 0; i < 16; i++) begin
      bus_clk <= 1'b0;
      bus_drv <= wr[i];
      half(1);
      bus_clk <= 1'b1;
      half(1);
      rd[i] = line;  // sampled late in the high phase, the slave answered at the fall
    end
    bus_drv <= 1'b1;  // released, the pull-up takes the line high
    half(30);         // clock setup before the end pulse
    bus_ident <= 1'b0;
    half(16);
    bus_ident <= 1'b1;
    half(2);
  endtask : xfer
endmodule : sbee_master

// ---- sim/tb_serial_bus_eeprom_slave_access.sv ----
`timescale 1ns/100ps
// self-checking bench for the serial eeprom slave
module tb_serial_bus_eeprom_slave_access;
  localparam int PROG = 2000;  // shortened programming time, longer than four transactions

  logic        core_clk = 1'b0;  // 20 MHz core clock
  logic        resetn   = 1'b0;  // synchronous reset, active low
  logic        safe     = 1'b0;  // write guard
  logic        option   = 1'b0;  // address-set strap
  wire         bus_clk;          // bus clock from the master
  wire         bus_ident;        // strobe from the master
  wire         bus_drv;          // master pull on the data line
  wire         dout;             // device drive value
  wire         oe_n;             // device drive enable, low pulls
  wire         line;             // wired-and data line with pull-up
  logic [7:0]  ld_a;             // load address of the active set
  logic [7:0]  rd_a;             // read address of the active set
  logic [7:0]  pg_a;             // program address of the active set
  logic [15:0] rd;               // word seen on the line
  int          mismatches = 0;
  int          checks     = 0;

  // open drain: either party pulling low wins over the pull-up
  assign line = bus_drv & (oe_n ? 1'b1 : dout);

  always #25 core_clk = ~core_clk;

  sbee_core #(.PROG_CYCLES(PROG)) u_sbee_core (
    .CORE_CLK      (core_clk),
    .RESETN        (resetn),
    .BUS_CLK       (bus_clk),
    .BUS_IDENT     (bus_ident),
    .BUS_DATA_IN   (line),
    .BUS_DATA_OUT  (dout),
    .BUS_DATA_OE_N (oe_n),
    .SAFE          (safe),
    .OPTION        (option)
  );

  sbee_master u_sbee_master (
    .core_clk  (core_clk),
    .line      (line),
    .bus_clk   (bus_clk),
    .bus_ident (bus_ident),
    .bus_drv   (bus_drv)
  );

  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // pick the address set to match the strap
  task automatic use_set(input logic hi);
    ld_a = hi ? sbee_pkg::ADR_LOAD_HI : sbee_pkg::ADR_LOAD_LO;
    rd_a = hi ? sbee_pkg::ADR_READ_HI : sbee_pkg::ADR_READ_LO;
    pg_a = hi ? sbee_pkg::ADR_PROG_HI : sbee_pkg::ADR_PROG_LO;
  endtask : use_set

  task automatic load(input logic [9:0] m);
    u_sbee_master.xfer(ld_a, {6'h00, m}, rd);
  endtask : load

  task automatic prog(input logic [7:0] d);
    u_sbee_master.xfer(pg_a, {8'h00, d}, rd);
  endtask : prog

  // read word: stored byte then eight released ones
  task automatic read_chk(input string what, input logic [7:0] exp);
    u_sbee_master.xfer(rd_a, 16'hffff, rd);
    check(what, rd, {8'hff, exp});
  endtask : read_chk

  task automatic settle();
    repeat (PROG + 100) @(posedge core_clk);
  endtask : settle

  // plain write and read back, top index, busy location idle
  task automatic t_basic();
    load(10'h014);
    prog(8'h5a);
    settle();
    read_chk("byte 20", 8'h5a);
    load(10'h1ff);
    prog(8'ha5);
    settle();
    read_chk("byte 511", 8'ha5);
    load(sbee_pkg::BUSY_LOC);
    read_chk("busy idle", 8'h00);
  endtask : t_basic

  // busy byte readable mid-pass; load and program while busy are both dropped
  task automatic t_busy();
    load(10'h028);
    prog(8'h11);
    load(sbee_pkg::BUSY_LOC);
    read_chk("busy set", 8'h02);
    load(10'h014);
    prog(8'h22);
    settle();
    read_chk("byte 40 after busy", 8'h11);
    load(10'h014);
    read_chk("byte 20 untouched", 8'h5a);
  endtask : t_busy

  // protected byte needs the guard high
  task automatic t_prot();
    safe <= 1'b1;
    load(10'h005);
    prog(8'h3c);
    settle();
    read_chk("guarded write", 8'h3c);
    safe <= 1'b0;
    prog(8'h00);
    settle();
    read_chk("refused write", 8'h3c);
  endtask : t_prot

  // each strap level answers only its own set
  task automatic t_strap();
    option <= 1'b1;
    use_set(1'b1);
    u_sbee_master.xfer(sbee_pkg::ADR_READ_LO, 16'hffff, rd);
    check("low set with strap high", rd, 16'hffff);
    load(10'h014);
    read_chk("high set read", 8'h5a);
    option <= 1'b0;
    use_set(1'b0);
    u_sbee_master.xfer(sbee_pkg::ADR_READ_HI, 16'hffff, rd);
    check("high set with strap low", rd, 16'hffff);
    u_sbee_master.xfer(8'h82, 16'hffff, rd);
    check("unused address", rd, 16'hffff);
    read_chk("low set read", 8'h5a);
  endtask : t_strap

  // reset cancels programming but keeps the address register
  task automatic t_reset();
    load(10'h03c);
    prog(8'h99);
    settle();
    prog(8'h77);
    repeat (100) @(posedge core_clk);
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    settle();
    read_chk("aborted write", 8'h99);
  endtask : t_reset

  task automatic give_verdict();
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  // main sequence
  initial begin
    use_set(1'b0);
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_basic();
    t_busy();
    t_prot();
    t_strap();
    t_reset();
    give_verdict();
  end
endmodule : tb_serial_bus_eeprom_slave_access
